//--- src/hrb_pkg.sv
// constants, types and state layout of the host request block
// What this block does
// - request block lives at local DFE90h
// - code 00 only interrupts the host
// - 01 modifies, 02 restores open options
// - 03 inserts into ring, 04 removes
// - 05 enters remote wake-up mode
// - 08 returns log, then zeroes counters
// - 0C enables or disables multicast reception
// - 13 dumps monitoring statistics counters
// - 1F selects the receive mode
// - data port write stores byte or word
// - local address never auto-increments
// - wake-up pattern return code at offset 2
// - flag 0001 adds, 0002 deletes pattern
// - mask size at offset 6, 0..12
// - pattern offset at 8, 0..255
// - pattern length at 10, 1..96
// - set mask bit skips byte compare
// - wake-up command allowed before open, repeatedly
// - close ends ring, restores buffer register
// - statistics copied to scratch, then cleared
package hrb_pkg;
    localparam logic [19:0] HRB_ADDR     = 20'hdfe90;
    localparam logic [19:0] SCRATCH_ADDR = 20'hdfef0;
    localparam logic [19:0] WIN_BASE     = 20'hdfe00;
    localparam int          WIN_SIZE     = 512;
    localparam logic [8:0]  HRB_IDX      = HRB_ADDR[8:0];
    localparam logic [8:0]  SCR_IDX      = SCRATCH_ADDR[8:0];
    localparam logic [7:0]  REG_MAC      = 8'h00;
    localparam logic [7:0]  REG_DATA     = 8'h04;
    localparam logic [7:0]  REG_ISR      = 8'h08;
    localparam logic [7:0]  REG_RBR      = 8'h0c;
    localparam logic [7:0]  REG_STAT     = 8'h10;
    localparam int          ISR_CBR_BIT  = 0;
    localparam logic [3:0]  OP_PRIV_WR   = 4'h1;
    localparam logic [7:0]  CMD_REQ_INT  = 8'h00;
    localparam logic [7:0]  CMD_MOD_OPT  = 8'h01;
    localparam logic [7:0]  CMD_RST_OPT  = 8'h02;
    localparam logic [7:0]  CMD_OPEN     = 8'h03;
    localparam logic [7:0]  CMD_CLOSE    = 8'h04;
    localparam logic [7:0]  CMD_SLEEP    = 8'h05;
    localparam logic [7:0]  CMD_GROUP    = 8'h06;
    localparam logic [7:0]  CMD_FUNCT    = 8'h07;
    localparam logic [7:0]  CMD_READ_LOG = 8'h08;
    localparam logic [7:0]  CMD_MCAST    = 8'h0c;
    localparam logic [7:0]  CMD_WAKE     = 8'h0d;
    localparam logic [7:0]  CMD_STATS    = 8'h13;
    localparam logic [7:0]  CMD_RX_MODE  = 8'h1f;
    localparam logic [7:0]  RC_OK        = 8'h00;
    localparam logic [7:0]  RC_BAD_CMD   = 8'h01;
    localparam logic [7:0]  RC_CLOSED    = 8'h04;
    localparam logic [7:0]  RC_BAD_OPT   = 8'h06;
    localparam logic [7:0]  RC_NA        = 8'h46;
    localparam logic [7:0]  OFS_CMD      = 8'h00;
    localparam logic [7:0]  OFS_RC       = 8'h02;
    localparam logic [7:0]  OFS_ARG      = 8'h04;
    localparam logic [7:0]  OFS_MSIZE    = 8'h06;
    localparam logic [7:0]  OFS_POFS     = 8'h08;
    localparam logic [7:0]  OFS_PLEN     = 8'h0a;
    localparam logic [7:0]  OFS_MASK     = 8'h0c;
    localparam logic [7:0]  OFS_OPEN_OPT = 8'h08;
    localparam logic [15:0] FLAG_ADD     = 16'h0001;
    localparam logic [15:0] FLAG_DEL     = 16'h0002;
    localparam logic [15:0] MASK_MAX     = 16'h000c;
    localparam logic [15:0] POFS_MAX     = 16'h00ff;
    localparam logic [15:0] PLEN_MAX     = 16'h0060;
    localparam int          MASK_BITS    = 96;
    localparam int          NCNT         = 4;
    localparam int          CNT_W        = 16;
    localparam logic [2:0]  LAST_COPY    = 3'h7;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_DECODE = 2'b01,
        ST_COPY   = 2'b11,
        ST_RETN   = 2'b10
    } hrb_fsm_t;

    typedef struct packed {
        logic        word;
        logic [3:0]  op;
        logic [19:0] addr;
    } hrb_mac_t;

    typedef struct packed {
        hrb_fsm_t                  st;
        logic                      cbr;
        hrb_mac_t                  mac;
        logic [15:0]               rbr;
        logic [15:0]               saved_rbr;
        logic [15:0]               opt;
        logic [15:0]               saved_opt;
        logic                      open;
        logic                      sleep;
        logic                      mcast;
        logic [7:0]                rmode;
        logic [7:0]                rc;
        logic                      rc_wr;
        logic [2:0]                idx;
        logic [NCNT-1:0][CNT_W-1:0] cnt;
        logic [3:0]                wcnt;
        logic [7:0]                wofs;
        logic [6:0]                wlen;
        logic [MASK_BITS-1:0]      wcmp;
        logic                      intr;
        logic [31:0]               rdata;
    } hrb_state_t;

    // every field clears at reset
    localparam hrb_state_t RST_STATE = '0;
endpackage

//--- src/hrb_host_request_block.sv
// request block intake and command processor of the adapter
module hrb_host_request_block #(
    parameter logic [3:0] WAKE_SLOTS = 4'h4
) (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire logic                         ce,
    // register port
    input  wire logic [7:0]                   reg_addr,
    input  wire logic [31:0]                  reg_wdata,
    input  wire logic                         reg_we,
    input  wire logic                         reg_re,
    output logic      [31:0]                  reg_rdata,
    // statistics events
    input  wire logic [hrb_pkg::NCNT-1:0]     stat_event,
    // adapter state
    output logic                              host_intr,
    output logic                              ring_inserted,
    output logic                              sleep_mode,
    output logic                              multicast_en,
    output logic      [7:0]                   receive_mode,
    output logic      [15:0]                  open_options,
    output logic      [15:0]                  ring_buffer_reg,
    // wake-up pattern
    output logic      [3:0]                   wake_patterns,
    output logic      [7:0]                   wake_pat_ofs,
    output logic      [6:0]                   wake_pat_len,
    output logic      [hrb_pkg::MASK_BITS-1:0] wake_compare_en
);
    hrb_pkg::hrb_state_t q;
    hrb_pkg::hrb_state_t d;
    logic [7:0]          mem [0:hrb_pkg::WIN_SIZE-1];
    logic                host_wr;
    logic [8:0]          h_idx;
    logic                fsm_we;
    logic [8:0]          fsm_idx;
    logic [7:0]          fsm_wd;
    logic [7:0]          cmd;
    logic [15:0]         wflag;
    logic [15:0]         wmsz;
    logic [15:0]         wpofs;
    logic [15:0]         wplen;
    logic                wbad;
    logic [15:0]         cword;
    logic [7:0]          cbyte;

    function automatic logic in_win(input logic [19:0] a);
        return a[19:9] == hrb_pkg::WIN_BASE[19:9];
    endfunction

    function automatic logic [7:0] blk_rd(input logic [7:0] ofs);
        return mem[hrb_pkg::HRB_IDX + {1'b0, ofs}];
    endfunction

    function automatic logic [15:0] blk_rd16(input logic [7:0] ofs);
        return {blk_rd(ofs + 8'h01), blk_rd(ofs)};
    endfunction

    // address held as written, never stepped
    assign h_idx   = q.mac.addr[8:0];
    assign host_wr = ce && reg_we && reg_addr == hrb_pkg::REG_DATA
                     && q.mac.op == hrb_pkg::OP_PRIV_WR && in_win(q.mac.addr);
    assign cmd     = blk_rd(hrb_pkg::OFS_CMD);
    assign wflag   = blk_rd16(hrb_pkg::OFS_ARG);
    assign wmsz    = blk_rd16(hrb_pkg::OFS_MSIZE);
    assign wpofs   = blk_rd16(hrb_pkg::OFS_POFS);
    assign wplen   = blk_rd16(hrb_pkg::OFS_PLEN);
    assign wbad    = !(wflag == hrb_pkg::FLAG_ADD || wflag == hrb_pkg::FLAG_DEL)
                     || wmsz > hrb_pkg::MASK_MAX || wpofs > hrb_pkg::POFS_MAX
                     || wplen == 16'h0000 || wplen > hrb_pkg::PLEN_MAX;
    assign cword   = q.cnt[q.idx[2:1]];
    assign cbyte   = q.idx[0] ? cword[15:8] : cword[7:0];

    // host data writes win the port; the processor waits
    always_ff @(posedge clk) begin
        if (host_wr) begin
            mem[h_idx] <= reg_wdata[7:0];
            if (q.mac.word) begin
                mem[h_idx + 9'h001] <= reg_wdata[15:8];
            end
        end else if (ce && fsm_we) begin
            mem[fsm_idx] <= fsm_wd;
        end
    end

    always_comb begin
        d       = q;
        d.intr  = 1'b0;
        d.rdata = '0;
        fsm_we  = 1'b0;
        fsm_idx = '0;
        fsm_wd  = '0;
        for (int i = 0; i < hrb_pkg::NCNT; i++) begin
            if (stat_event[i]) begin
                d.cnt[i] = q.cnt[i] + 16'h0001;
            end
        end
        unique case (q.st)
            hrb_pkg::ST_IDLE: begin
                if (q.cbr) begin
                    d.cbr = 1'b0;
                    d.st  = hrb_pkg::ST_DECODE;
                end
            end
            hrb_pkg::ST_DECODE: begin
                d.rc    = hrb_pkg::RC_OK;
                d.rc_wr = 1'b1;
                d.st    = hrb_pkg::ST_RETN;
                case (cmd)
                    hrb_pkg::CMD_REQ_INT: begin
                        d.rc_wr = 1'b0;
                    end
                    hrb_pkg::CMD_MOD_OPT: begin
                        if (q.open) begin
                            d.opt = blk_rd16(hrb_pkg::OFS_ARG);
                        end else begin
                            d.rc = hrb_pkg::RC_CLOSED;
                        end
                    end
                    hrb_pkg::CMD_RST_OPT: begin
                        if (q.open) begin
                            d.opt = q.saved_opt;
                        end else begin
                            d.rc = hrb_pkg::RC_CLOSED;
                        end
                    end
                    hrb_pkg::CMD_OPEN: begin
                        d.open      = 1'b1;
                        d.opt       = blk_rd16(hrb_pkg::OFS_OPEN_OPT);
                        d.saved_opt = blk_rd16(hrb_pkg::OFS_OPEN_OPT);
                        d.saved_rbr = q.rbr;
                    end
                    hrb_pkg::CMD_CLOSE: begin
                        // nothing is queued, so dropped work needs no undo
                        d.open = 1'b0;
                        d.rbr  = q.saved_rbr;
                    end
                    hrb_pkg::CMD_SLEEP: begin
                        d.sleep = 1'b1;
                    end
                    hrb_pkg::CMD_GROUP, hrb_pkg::CMD_FUNCT: begin
                        d.rc = hrb_pkg::RC_OK;
                    end
                    hrb_pkg::CMD_READ_LOG: begin
                        d.idx = '0;
                        d.st  = hrb_pkg::ST_COPY;
                    end
                    hrb_pkg::CMD_MCAST: begin
                        d.mcast = blk_rd(hrb_pkg::OFS_ARG) != 8'h00;
                    end
                    hrb_pkg::CMD_WAKE: begin
                        // accepted open or closed, repeatedly; adds past WAKE_SLOTS patterns get RC_NA
                        if (wbad) begin
                            d.rc = hrb_pkg::RC_BAD_OPT;
                        end else if (wflag == hrb_pkg::FLAG_ADD) begin
                            if (q.wcnt == WAKE_SLOTS) begin
                                d.rc = hrb_pkg::RC_NA;
                            end else begin
                                d.wcnt = q.wcnt + 4'h1;
                                d.wofs = wpofs[7:0];
                                d.wlen = wplen[6:0];
                                for (int n = 0; n < hrb_pkg::MASK_BITS; n++) begin
                                    d.wcmp[n] = 16'(n) < wplen && !(16'(n) < {wmsz[12:0], 3'h0}
                                                && blk_rd(hrb_pkg::OFS_MASK + 8'(n / 8))[n % 8]);
                                end
                            end
                        end else if (q.wcnt == 4'h0) begin
                            d.rc = hrb_pkg::RC_NA;
                        end else begin
                            d.wcnt = q.wcnt - 4'h1;
                        end
                    end
                    hrb_pkg::CMD_STATS: begin
                        if (q.open) begin
                            d.idx = '0;
                            d.st  = hrb_pkg::ST_COPY;
                        end else begin
                            d.rc = hrb_pkg::RC_CLOSED;
                        end
                    end
                    hrb_pkg::CMD_RX_MODE: begin
                        d.rmode = blk_rd(hrb_pkg::OFS_ARG);
                    end
                    default: begin
                        d.rc = hrb_pkg::RC_BAD_CMD;
                    end
                endcase
            end
            hrb_pkg::ST_COPY: begin
                fsm_we  = 1'b1;
                fsm_idx = hrb_pkg::SCR_IDX + {6'h00, q.idx};
                fsm_wd  = cbyte;
                if (!host_wr) begin
                    d.idx = q.idx + 3'h1;
                    if (q.idx == hrb_pkg::LAST_COPY) begin
                        // an event in the clearing cycle still counts
                        for (int i = 0; i < hrb_pkg::NCNT; i++) begin
                            d.cnt[i] = hrb_pkg::CNT_W'(stat_event[i]);
                        end
                        d.st = hrb_pkg::ST_RETN;
                    end
                end
            end
            hrb_pkg::ST_RETN: begin
                fsm_we  = q.rc_wr;
                fsm_idx = hrb_pkg::HRB_IDX + {1'b0, hrb_pkg::OFS_RC};
                fsm_wd  = q.rc;
                if (!(q.rc_wr && host_wr)) begin
                    d.intr  = 1'b1;
                    d.rc_wr = 1'b0;
                    d.st    = hrb_pkg::ST_IDLE;
                end
            end
        endcase
        if (reg_re) begin
            case (reg_addr)
                hrb_pkg::REG_MAC:  d.rdata = {7'h00, q.mac};
                hrb_pkg::REG_DATA: begin
                    if (in_win(q.mac.addr)) begin
                        d.rdata = {16'h0000, q.mac.word ? mem[h_idx + 9'h001] : 8'h00,
                                   mem[h_idx]};
                    end
                end
                hrb_pkg::REG_ISR:  d.rdata = {31'h0, q.cbr};
                hrb_pkg::REG_RBR:  d.rdata = {16'h0000, q.rbr};
                hrb_pkg::REG_STAT: d.rdata = {q.opt, q.rmode, q.wcnt, q.st != hrb_pkg::ST_IDLE,
                                              q.mcast, q.sleep, q.open};
                default:           d.rdata = '0;
            endcase
        end
        if (reg_we) begin
            case (reg_addr)
                hrb_pkg::REG_MAC: d.mac = hrb_pkg::hrb_mac_t'(reg_wdata[24:0]);
                hrb_pkg::REG_ISR: begin
                    if (reg_wdata[hrb_pkg::ISR_CBR_BIT]) begin
                        d.cbr = 1'b1;
                    end
                end
                hrb_pkg::REG_RBR: d.rbr = reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= hrb_pkg::RST_STATE;
        end else if (ce) begin
            q <= d;
        end
    end

    assign reg_rdata       = q.rdata;
    assign host_intr       = q.intr;
    assign ring_inserted   = q.open;
    assign sleep_mode      = q.sleep;
    assign multicast_en    = q.mcast;
    assign receive_mode    = q.rmode;
    assign open_options    = q.opt;
    assign ring_buffer_reg = q.rbr;
    assign wake_patterns   = q.wcnt;
    assign wake_pat_ofs    = q.wofs;
    assign wake_pat_len    = q.wlen;
    assign wake_compare_en = q.wcmp;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_idle_waits: assert property (
        ce && q.st == hrb_pkg::ST_IDLE && !q.cbr |=> q.st == hrb_pkg::ST_IDLE)
        else $error("left idle without doorbell");
    a_take_clears: assert property (
        ce && q.st == hrb_pkg::ST_IDLE && q.cbr && !reg_we
        |=> q.st == hrb_pkg::ST_DECODE && !q.cbr)
        else $error("doorbell not taken and cleared");
    a_req_int_only: assert property (
        ce && q.st == hrb_pkg::ST_DECODE && cmd == hrb_pkg::CMD_REQ_INT
        |=> !q.rc_wr && $stable(q.open) && $stable(q.opt) ##1 (!ce || host_intr))
        else $error("request interrupt misbehaved");
    a_open_insert: assert property (
        ce && q.st == hrb_pkg::ST_DECODE && cmd == hrb_pkg::CMD_OPEN
        |=> ring_inserted && q.saved_rbr == $past(q.rbr))
        else $error("open did not insert");
    a_close_restore: assert property (
        ce && q.st == hrb_pkg::ST_DECODE && cmd == hrb_pkg::CMD_CLOSE && !reg_we
        |=> !ring_inserted && ring_buffer_reg == $past(q.saved_rbr))
        else $error("close did not restore");
    a_sleep_set: assert property (
        ce && q.st == hrb_pkg::ST_DECODE && cmd == hrb_pkg::CMD_SLEEP |=> sleep_mode)
        else $error("sleep not entered");
    a_mcast_follow: assert property (
        ce && q.st == hrb_pkg::ST_DECODE && cmd == hrb_pkg::CMD_MCAST
        |=> multicast_en == ($past(blk_rd(hrb_pkg::OFS_ARG)) != 8'h00))
        else $error("multicast mode wrong");
    a_stats_clear: assert property (
        ce && q.st == hrb_pkg::ST_COPY && q.idx == hrb_pkg::LAST_COPY && !host_wr
        |=> q.cnt[0] <= 16'h0001 && q.cnt[3] <= 16'h0001 && q.st == hrb_pkg::ST_RETN)
        else $error("counters not cleared after copy");
    a_wake_badlen: assert property (
        ce && q.st == hrb_pkg::ST_DECODE && cmd == hrb_pkg::CMD_WAKE
        && (wplen == 16'h0000 || wplen > hrb_pkg::PLEN_MAX)
        |=> q.rc == hrb_pkg::RC_BAD_OPT && $stable(q.wcnt))
        else $error("bad pattern length accepted");
    a_rc_stored: assert property (
        ce && q.st == hrb_pkg::ST_RETN && q.rc_wr && !host_wr
        |=> mem[hrb_pkg::HRB_IDX + 9'h002] == $past(q.rc) && host_intr)
        else $error("return code not stored");
    a_addr_held: assert property (
        !(ce && reg_we && reg_addr == hrb_pkg::REG_MAC) |=> $stable(q.mac))
        else $error("access address moved");
    a_byte_store: assert property (
        host_wr |=> mem[$past(h_idx)] == $past(reg_wdata[7:0]))
        else $error("data port byte not stored");
endmodule

//--- test/hrb_host_model.sv
// host driver model: register bus cycles and request block issue
module hrb_host_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // register port
    output logic      [7:0]  reg_addr,
    output logic      [31:0] reg_wdata,
    output logic             reg_we,
    output logic             reg_re
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        reg_we    = 1'b0;
        reg_re    = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_we    <= 1'b1;
        @(posedge clk);
        reg_we    <= 1'b0;
        // released data no longer shows the old value
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge clk);
        reg_re   <= 1'b0;
    endtask

    task automatic point(input logic word, input logic [19:0] la);
        wr(hrb_pkg::REG_MAC, {7'h0, word, hrb_pkg::OP_PRIV_WR, la});
    endtask

    task automatic put16(input logic [19:0] la, input logic [15:0] v);
        point(1'b1, la);
        wr(hrb_pkg::REG_DATA, {16'h0, v});
    endtask

    task automatic issue(input logic [7:0] cmd, input logic [15:0] a4, a6, a8, a10, m12);
        logic [15:0] blk [12];
        blk = '{{8'h00, cmd}, 16'h00ff, a4, a6, a8, a10, m12, 16'h0, 16'h0, 16'h0, 16'h0,
                16'h0};
        if (cmd == hrb_pkg::CMD_WAKE) begin
            put16(hrb_pkg::SCRATCH_ADDR + 20'(a8), 16'ha55a);
        end
        for (int i = 0; i < 12; i++) begin
            put16(hrb_pkg::HRB_ADDR + 20'(2 * i), blk[i]);
        end
        wr(hrb_pkg::REG_ISR, 32'h1);
    endtask
endmodule

//--- test/host_request_block_commands_tb.sv
// self-checking bench for the request block command processor
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %0t mismatch got %0h exp %0h", $time, (g), (e)); end end
module host_request_block_commands_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        ce = 1'b1;
    logic        rst_b;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, e_v, w, b, o, tmp;
    logic        reg_we, reg_re, host_intr, ring_inserted, sleep_mode, multicast_en;
    logic [3:0]  stat_event, wake_patterns, ev;
    logic [7:0]  receive_mode, wake_pat_ofs;
    logic [15:0] open_options, ring_buffer_reg;
    logic [6:0]  wake_pat_len;
    logic [95:0] wake_compare_en;
    logic [31:0] seed = 32'd44;
    logic [31:0] exp_q [$];
    logic        pend = 1'b0;
    int          err_total = 0;
    int          checked = 0;
    int          tally [4];
    logic [15:0] bad [5][4] = '{'{16'h3, 16'h2, 16'h0, 16'hc}, '{16'h1, 16'hd, 16'h0, 16'hc},
        '{16'h1, 16'h2, 16'h100, 16'hc}, '{16'h1, 16'h2, 16'h0, 16'h0},
        '{16'h1, 16'h2, 16'h0, 16'h61}};

    always #2.5 clk = ~clk;

    hrb_host_model u_hrb_host_model (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re));

    hrb_host_request_block u_hrb_host_request_block (.clk(clk), .rst_b(rst_b), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .stat_event(stat_event), .host_intr(host_intr),
        .ring_inserted(ring_inserted), .sleep_mode(sleep_mode), .multicast_en(multicast_en),
        .receive_mode(receive_mode), .open_options(open_options),
        .ring_buffer_reg(ring_buffer_reg), .wake_patterns(wake_patterns),
        .wake_pat_ofs(wake_pat_ofs), .wake_pat_len(wake_pat_len),
        .wake_compare_en(wake_compare_en));

    // read data stands in the cycle after the strobe
    always @(negedge clk) begin
        if (pend) begin
            e_v = exp_q.pop_front();
            `CHK(reg_rdata, e_v)
        end
        pend = reg_re;
    end

    function automatic logic [31:0] nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic complete_run();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        u_hrb_host_model.rd(a);
    endtask

    task automatic rd_mem(input logic word, input logic [19:0] la, input logic [31:0] e);
        u_hrb_host_model.point(word, la);
        rd_exp(hrb_pkg::REG_DATA, e);
    endtask

    task automatic run(input logic [7:0] cmd, input logic [15:0] a4, a6, a8, a10, m12,
                       input logic [7:0] rc);
        int n;
        n = 0;
        u_hrb_host_model.issue(cmd, a4, a6, a8, a10, m12);
        while (host_intr !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        `CHK(host_intr, 1'b1)
        rd_mem(1'b0, hrb_pkg::HRB_ADDR + 20'h2, {24'h0, rc});
        @(negedge clk);
    endtask

    task automatic stat_chk(input logic [7:0] cmd);
        for (int k = 0; k < 4; k++) tally[k] = 0;
        repeat (20) begin
            @(posedge clk);
            tmp = nxt();
            ev = tmp[3:0];
            stat_event <= ev;
            for (int k = 0; k < 4; k++) tally[k] += int'(ev[k]);
        end
        @(posedge clk);
        stat_event <= 4'h0;
        run(cmd, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, hrb_pkg::RC_OK);
        for (int k = 0; k < 4; k++) begin
            rd_mem(1'b1, hrb_pkg::SCRATCH_ADDR + 20'(2 * k), {16'h0, 16'(tally[k])});
        end
    endtask

    initial begin
        #100us;
        err_total++;
        complete_run();
    end

    initial begin
        rst_b = 1'b0;
        stat_event = 4'h0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        `CHK({ring_inserted, sleep_mode, wake_patterns, host_intr}, 7'h0)
        // frozen clock enable drops the write
        ce <= 1'b0;
        u_hrb_host_model.wr(hrb_pkg::REG_RBR, 32'h0000ffff);
        @(posedge clk);
        ce <= 1'b1;
        rd_exp(hrb_pkg::REG_RBR, 32'h0);
        w = nxt();
        b = nxt();
        u_hrb_host_model.point(1'b1, 20'hdff40);
        u_hrb_host_model.wr(hrb_pkg::REG_DATA, {16'h0, w[15:0]});
        u_hrb_host_model.point(1'b0, 20'hdff40);
        u_hrb_host_model.wr(hrb_pkg::REG_DATA, {24'h0, b[7:0]});
        u_hrb_host_model.wr(hrb_pkg::REG_DATA, {24'h0, b[15:8]});
        rd_mem(1'b1, 20'hdff40, {16'h0, w[15:8], b[15:8]});
        rd_exp(8'h40, 32'h0);
        run(hrb_pkg::CMD_STATS, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, hrb_pkg::RC_CLOSED);
        run(hrb_pkg::CMD_MOD_OPT, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, hrb_pkg::RC_CLOSED);
        run(8'h0e, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, hrb_pkg::RC_BAD_CMD);
        run(hrb_pkg::CMD_REQ_INT, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 8'hff);
        run(hrb_pkg::CMD_WAKE, 16'h1, 16'h2, 16'h10, 16'hc, 16'h000f, hrb_pkg::RC_OK);
        `CHK({wake_patterns, wake_pat_ofs, wake_pat_len}, {4'h1, 8'h10, 7'hc})
        `CHK(wake_compare_en, 96'hff0)
        for (int i = 0; i < 5; i++) begin
            run(hrb_pkg::CMD_WAKE, bad[i][0], bad[i][1], bad[i][2], bad[i][3], 16'h0,
                hrb_pkg::RC_BAD_OPT);
        end
        run(hrb_pkg::CMD_WAKE, 16'h2, 16'h0, 16'h0, 16'h1, 16'h0, hrb_pkg::RC_OK);
        `CHK(wake_patterns, 4'h0)
        run(hrb_pkg::CMD_WAKE, 16'h2, 16'h0, 16'h0, 16'h1, 16'h0, hrb_pkg::RC_NA);
        repeat (4) run(hrb_pkg::CMD_WAKE, 16'h1, 16'hc, 16'hff, 16'h60, 16'h0, hrb_pkg::RC_OK);
        `CHK({wake_patterns, wake_pat_ofs, wake_pat_len}, {4'h4, 8'hff, 7'h60})
        `CHK(wake_compare_en, {96{1'b1}})
        run(hrb_pkg::CMD_WAKE, 16'h1, 16'hc, 16'hff, 16'h60, 16'h0, hrb_pkg::RC_NA);
        u_hrb_host_model.wr(hrb_pkg::REG_RBR, {16'h0, w[15:0]});
        o = nxt();
        run(hrb_pkg::CMD_OPEN, 16'h0, 16'h0, o[15:0], 16'h0, 16'h0, hrb_pkg::RC_OK);
        `CHK({ring_inserted, open_options}, {1'b1, o[15:0]})
        run(hrb_pkg::CMD_MOD_OPT, b[15:0], 16'h0, 16'h0, 16'h0, 16'h0, hrb_pkg::RC_OK);
        `CHK(open_options, b[15:0])
        run(hrb_pkg::CMD_RST_OPT, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, hrb_pkg::RC_OK);
        `CHK(open_options, o[15:0])
        run(hrb_pkg::CMD_MCAST, 16'h1, 16'h0, 16'h0, 16'h0, 16'h0, hrb_pkg::RC_OK);
        `CHK(multicast_en, 1'b1)
        run(hrb_pkg::CMD_MCAST, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, hrb_pkg::RC_OK);
        `CHK(multicast_en, 1'b0)
        run(hrb_pkg::CMD_RX_MODE, b[15:0], 16'h0, 16'h0, 16'h0, 16'h0, hrb_pkg::RC_OK);
        `CHK(receive_mode, b[7:0])
        stat_chk(hrb_pkg::CMD_READ_LOG);
        stat_chk(hrb_pkg::CMD_STATS);
        run(hrb_pkg::CMD_SLEEP, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, hrb_pkg::RC_OK);
        `CHK(sleep_mode, 1'b1)
        u_hrb_host_model.wr(hrb_pkg::REG_RBR, ~w);
        run(hrb_pkg::CMD_CLOSE, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, hrb_pkg::RC_OK);
        `CHK({ring_inserted, ring_buffer_reg}, {1'b0, w[15:0]})
        rd_exp(hrb_pkg::REG_STAT, {o[15:0], b[7:0], 8'h42});
        rd_exp(hrb_pkg::REG_ISR, 32'h0);
        repeat (4) @(posedge clk);
        complete_run();
    end
endmodule
